//--- logic/sso_status_out.sv
`timescale 1ns/1ps
module sso_status_out #(
  parameter int unsigned TICKS_PER_SEC = sso_pkg::SEC_CYCLES
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic      [31:0]       hrdata,
  input  wire sso_pkg::sso_cond_t cond_in,
  output logic                   servo_alarm_out,
  output logic                   servo_ready_out,
  output logic                   brake_release_out,
  output logic                   positioning_done_out,
  output logic                   positioning_done_second_out,
  output logic                   speed_arrival_out,
  output logic                   torque_limited_out,
  output logic                   zero_speed_out,
  output logic                   speed_match_out,
  output logic                   warning_out_first,
  output logic                   warning_out_second,
  output logic                   output_channel_one,
  output logic                   output_channel_two,
  output logic                   output_channel_three,
  output logic                   output_channel_four,
  output logic                   output_channel_five,
  output logic                   output_channel_six,
  output logic                   irq
);

  sso_pkg::sso_cond_t cond_m;
  sso_pkg::sso_cond_t cond_s;

  logic        wr_pend;
  logic [7:0]  addr_q;
  logic [23:0] chmap;
  logic [4:0]  wsel_first;
  logic [4:0]  wsel_second;
  logic [15:0] wmask;
  logic [3:0]  wlatch;
  logic [2:0]  irq_stat;
  logic [2:0]  irq_mask;
  logic [15:0] fn_q;
  logic [5:0]  ch_q;
  logic [11:0] held;
  logic [11:0] held_prev;
  logic [31:0] sec_cnt;

  logic        take;
  logic        hit_in_page;
  logic [31:0] rd_val;
  logic        wr_chmap;
  logic        wr_wsel;
  logic        wr_wmask;
  logic        wr_wlatch;
  logic        wr_wstat;
  logic        wr_istat;
  logic        wr_imask;
  logic [11:0] wstat_clr;
  logic [2:0]  irq_clr;
  logic [2:0]  irq_ev;
  logic [15:0] fn_now;
  logic [5:0]  ch_now;
  logic        sec_tick;
  logic        ready_now;

  // Condition inputs come from other clocked logic of the drive
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cond_m <= '0;
      cond_s <= '0;
    end else begin
      cond_m <= cond_in;
      cond_s <= cond_m;
    end
  end

  // Bus slave: zero wait states, always OKAY
  assign hreadyout   = 1'b1;
  assign hresp       = 1'b0;
  assign take        = hsel && hready && htrans[1];
  assign hit_in_page = (haddr[31:8] == 24'h000000);

  assign rd_val =
    !hit_in_page                      ? 32'h00000000 :
    haddr[7:0] == sso_pkg::OFF_CHMAP    ? {8'h00, chmap} :
    haddr[7:0] == sso_pkg::OFF_WSEL     ? {19'h00000, wsel_second, 3'h0, wsel_first} :
    haddr[7:0] == sso_pkg::OFF_WMASK    ? {16'h0000, wmask} :
    haddr[7:0] == sso_pkg::OFF_WLATCH   ? {28'h0000000, wlatch} :
    haddr[7:0] == sso_pkg::OFF_FUNC     ? {16'h0000, fn_q} :
    haddr[7:0] == sso_pkg::OFF_WSTAT    ? {20'h00000, held} :
    haddr[7:0] == sso_pkg::OFF_IRQ_STAT ? {29'h00000000, irq_stat} :
    haddr[7:0] == sso_pkg::OFF_IRQ_MASK ? {29'h00000000, irq_mask} :
                                          32'h00000000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      addr_q  <= 8'h00;
      hrdata  <= 32'h00000000;
    end else begin
      wr_pend <= take && hwrite && hit_in_page;
      if (take) begin
        addr_q <= haddr[7:0];
      end
      if (take && !hwrite) begin
        hrdata <= rd_val;
      end
    end
  end

  assign wr_chmap  = wr_pend && (addr_q == sso_pkg::OFF_CHMAP);
  assign wr_wsel   = wr_pend && (addr_q == sso_pkg::OFF_WSEL);
  assign wr_wmask  = wr_pend && (addr_q == sso_pkg::OFF_WMASK);
  assign wr_wlatch = wr_pend && (addr_q == sso_pkg::OFF_WLATCH);
  assign wr_wstat  = wr_pend && (addr_q == sso_pkg::OFF_WSTAT);
  assign wr_istat  = wr_pend && (addr_q == sso_pkg::OFF_IRQ_STAT);
  assign wr_imask  = wr_pend && (addr_q == sso_pkg::OFF_IRQ_MASK);
  assign wstat_clr = wr_wstat ? hwdata[11:0] : 12'h000;
  assign irq_clr   = wr_istat ? hwdata[2:0] : 3'h0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chmap       <= sso_pkg::CHMAP_RST;
      wsel_first  <= sso_pkg::WSEL_RST;
      wsel_second <= sso_pkg::WSEL_RST;
      wmask       <= sso_pkg::WMASK_RST;
      wlatch      <= sso_pkg::WLATCH_RST;
      irq_mask    <= 3'h0;
    end else begin
      if (wr_chmap) begin
        chmap <= hwdata[23:0];
      end
      if (wr_wsel) begin
        wsel_first  <= hwdata[sso_pkg::WSEL_FIRST_LSB +: 5];
        wsel_second <= hwdata[sso_pkg::WSEL_SECOND_LSB +: 5];
      end
      if (wr_wmask) begin
        wmask <= hwdata[15:0];
      end
      if (wr_wlatch) begin
        wlatch <= hwdata[3:0];
      end
      if (wr_imask) begin
        irq_mask <= hwdata[2:0];
      end
    end
  end

  // One-second tick for warning hold
  assign sec_tick = (sec_cnt == 32'(TICKS_PER_SEC - 1));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sec_cnt <= 32'h00000000;
    end else begin
      sec_cnt <= sec_tick ? 32'h00000000 : sec_cnt + 32'h00000001;
    end
  end

  sso_warn_latch u_warn (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .sec_tick (sec_tick),
    .raw      (cond_s.warn),
    .mask     (wmask),
    .hold_s   (wlatch),
    .clear    (wstat_clr),
    .held     (held)
  );

  // Function levels, active high means transistor on
  assign ready_now = cond_s.ctrl_power && cond_s.main_power && !cond_s.alarm;

  always_comb begin
    fn_now                      = 16'h0000;
    fn_now[sso_pkg::FN_ALARM]   = !cond_s.alarm;
    fn_now[sso_pkg::FN_READY]   = ready_now;
    fn_now[sso_pkg::FN_BRAKE]   = cond_s.brake_release;
    fn_now[sso_pkg::FN_INPOS]   = cond_s.pos_done;
    fn_now[sso_pkg::FN_INPOS2]  = cond_s.pos_done2;
    fn_now[sso_pkg::FN_ARRIVAL] = cond_s.speed_arrived;
    fn_now[sso_pkg::FN_TORQUE]  = cond_s.torque_limited;
    fn_now[sso_pkg::FN_ZERO]    = cond_s.zero_speed;
    fn_now[sso_pkg::FN_MATCH]   = cond_s.speed_match;
    fn_now[sso_pkg::FN_WARNING_OUT_FIRST]   = sso_pkg::warn_pick(held, wsel_first);
    fn_now[sso_pkg::FN_WARNING_OUT_SECOND]   = sso_pkg::warn_pick(held, wsel_second);
  end

  for (genvar c = 0; c < 6; c++) begin : g_chan
    assign ch_now[c] = fn_now[chmap[4*c +: 4]];
  end

  // Interrupt events
  assign irq_ev[sso_pkg::IRQ_ALARM]      = fn_q[sso_pkg::FN_ALARM] && cond_s.alarm;
  assign irq_ev[sso_pkg::IRQ_WARN]       = |(held & ~held_prev);
  assign irq_ev[sso_pkg::IRQ_READY_LOST] = fn_q[sso_pkg::FN_READY] && !ready_now;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fn_q      <= 16'h0000;
      ch_q      <= 6'h00;
      held_prev <= 12'h000;
      irq_stat  <= 3'h0;
    end else begin
      fn_q      <= fn_now;
      ch_q      <= ch_now;
      held_prev <= held;
      // Set wins over a simultaneous clear
      irq_stat  <= (irq_stat & ~irq_clr) | irq_ev;
    end
  end

  assign irq = |(irq_stat & irq_mask);

  assign servo_alarm_out             = fn_q[sso_pkg::FN_ALARM];
  assign servo_ready_out             = fn_q[sso_pkg::FN_READY];
  assign brake_release_out           = fn_q[sso_pkg::FN_BRAKE];
  assign positioning_done_out        = fn_q[sso_pkg::FN_INPOS];
  assign positioning_done_second_out = fn_q[sso_pkg::FN_INPOS2];
  assign speed_arrival_out           = fn_q[sso_pkg::FN_ARRIVAL];
  assign torque_limited_out          = fn_q[sso_pkg::FN_TORQUE];
  assign zero_speed_out              = fn_q[sso_pkg::FN_ZERO];
  assign speed_match_out             = fn_q[sso_pkg::FN_MATCH];
  assign warning_out_first           = fn_q[sso_pkg::FN_WARNING_OUT_FIRST];
  assign warning_out_second          = fn_q[sso_pkg::FN_WARNING_OUT_SECOND];
  assign output_channel_one          = ch_q[0];
  assign output_channel_two          = ch_q[1];
  assign output_channel_three        = ch_q[2];
  assign output_channel_four         = ch_q[3];
  assign output_channel_five         = ch_q[4];
  assign output_channel_six          = ch_q[5];

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_alarm_level: assert property (
    cond_s.alarm |=> !servo_alarm_out
  ) else $error("alarm output stays on during alarm");

  a_ready_gate: assert property (
    servo_ready_out |-> $past(cond_s.ctrl_power && cond_s.main_power && !cond_s.alarm)
  ) else $error("ready output on without both powers or with alarm");

  a_brake_timing: assert property (
    $rose(cond_s.brake_release) |=> brake_release_out ##1 $past(brake_release_out)
  ) else $error("brake release output not on one cycle after request");

  a_inpos_pair: assert property (
    {positioning_done_out, positioning_done_second_out} ==
      $past({cond_s.pos_done, cond_s.pos_done2})
  ) else $error("positioning complete outputs mismatch");

  a_arrival_follow: assert property (
    cond_s.speed_arrived ##1 cond_s.speed_arrived |-> speed_arrival_out
  ) else $error("speed arrival output late");

  a_torque_follow: assert property (
    !cond_s.torque_limited |=> !torque_limited_out
  ) else $error("torque limited output on without limit");

  a_zero_follow: assert property (
    zero_speed_out == $past(cond_s.zero_speed)
  ) else $error("zero speed output mismatch");

  a_match_follow: assert property (
    speed_match_out == $past(cond_s.speed_match)
  ) else $error("speed match output mismatch");

  a_warn_select: assert property (
    warning_out_second == $past(sso_pkg::warn_pick(held, wsel_second))
  ) else $error("second warning output ignores its select");

  a_warn_turn_on: assert property (
    (|sso_pkg::warn_unmasked(cond_s.warn, wmask) && wsel_first == 5'h00 &&
      !wr_wsel) |-> ##2 warning_out_first
  ) else $error("first warning output not on two cycles after warning");

  a_warn_or_all: assert property (
    (wsel_first == 5'h00) |=> (warning_out_first == $past(|held))
  ) else $error("select zero does not give OR of warnings");

  a_mask_block: assert property (
    (held == 12'h000 && sso_pkg::warn_unmasked(cond_s.warn, wmask) == 12'h000)
      |=> held == 12'h000
  ) else $error("masked warning was latched");

  a_nolimit_hold: assert property (
    (held[2] && !wstat_clr[2]) |=> held[2]
  ) else $error("battery warning released without clear");

  a_chan_map: assert property (
    output_channel_four == $past(fn_now[chmap[15:12]])
  ) else $error("channel four does not carry its mapped function");

  c_alarm_entry: cover property ($fell(servo_alarm_out));
  c_warn_first: cover property ($rose(warning_out_first));
  c_irq_raise: cover property ($rose(irq));

endmodule

//--- logic/sso_pkg.sv
package sso_pkg;

  // Clock and warning hold timing
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned HOLD_UNIT_NS  = 1_000_000_000;
  localparam int unsigned SEC_CYCLES    = HOLD_UNIT_NS / CLK_PERIOD_NS;
  localparam logic [3:0]  HOLD_MAX_S    = 4'hA;

  localparam int NWARN = 12;

  // Register byte offsets
  localparam logic [7:0] OFF_CHMAP    = 8'h00;
  localparam logic [7:0] OFF_WSEL     = 8'h04;
  localparam logic [7:0] OFF_WMASK    = 8'h08;
  localparam logic [7:0] OFF_WLATCH   = 8'h0C;
  localparam logic [7:0] OFF_FUNC     = 8'h10;
  localparam logic [7:0] OFF_WSTAT    = 8'h14;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h18;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h1C;

  // Field positions
  localparam int WSEL_FIRST_LSB  = 0;
  localparam int WSEL_SECOND_LSB = 8;
  localparam int IRQ_ALARM       = 0;
  localparam int IRQ_WARN        = 1;
  localparam int IRQ_READY_LOST  = 2;

  // Values after reset
  localparam logic [23:0] CHMAP_RST  = 24'h674123;
  localparam logic [4:0]  WSEL_RST   = 5'h00;
  localparam logic [15:0] WMASK_RST  = 16'h0000;
  localparam logic [3:0]  WLATCH_RST = 4'h1;

  typedef enum logic [3:0] {
    FN_NONE    = 4'h0,
    FN_ALARM   = 4'h1,
    FN_READY   = 4'h2,
    FN_BRAKE   = 4'h3,
    FN_INPOS   = 4'h4,
    FN_ARRIVAL = 4'h5,
    FN_TORQUE  = 4'h6,
    FN_ZERO    = 4'h7,
    FN_MATCH   = 4'h8,
    FN_INPOS2  = 4'h9,
    FN_WARNING_OUT_FIRST   = 4'hA,
    FN_WARNING_OUT_SECOND   = 4'hB
  } sso_func_code_t;

  typedef struct packed {
    logic        alarm;
    logic        ctrl_power;
    logic        main_power;
    logic        brake_release;
    logic        pos_done;
    logic        pos_done2;
    logic        speed_arrived;
    logic        torque_limited;
    logic        zero_speed;
    logic        speed_match;
    logic [11:0] warn;
  } sso_cond_t;

  // Mask bit per warning, warning 0 rightmost
  localparam logic [11:0][3:0] WARN_MASK_POS =
    {4'hE, 4'h7, 4'hA, 4'h8, 4'h2, 4'h9, 4'h3, 4'h4, 4'h6, 4'h0, 4'h5, 4'h7};
  // Battery and end-of-life warnings
  localparam logic [11:0] WARN_NO_LIMIT = 12'h084;
  localparam logic [4:0]  SEL_DETERIOR  = 5'h16;
  localparam logic [4:0]  SEL_MAINS_OFF = 5'h0E;
  localparam logic [4:0]  SEL_LAST_STD  = 5'h0A;

  function automatic logic [11:0] warn_unmasked(logic [11:0] raw, logic [15:0] mask);
    logic [11:0] r;
    r = '0;
    for (int i = 0; i < NWARN; i++) begin
      r[i] = raw[i] & ~mask[WARN_MASK_POS[i]];
    end
    return r;
  endfunction

  function automatic logic [11:0] sel_onehot(logic [4:0] code);
    logic [11:0] r;
    r = '0;
    if (code >= 5'h01 && code <= SEL_LAST_STD) begin
      r = 12'(12'h001 << (code - 5'h01));
    end else if (code == SEL_DETERIOR) begin
      r = 12'h400;
    end else if (code == SEL_MAINS_OFF) begin
      r = 12'h800;
    end
    return r;
  endfunction

  function automatic logic warn_pick(logic [11:0] held, logic [4:0] code);
    return (code == 5'h00) ? (|held) : (|(held & sel_onehot(code)));
  endfunction

endpackage

//--- logic/sso_warn_latch.sv
`timescale 1ns/1ps
module sso_warn_latch (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        sec_tick,
  input  wire logic [11:0] raw,
  input  wire logic [15:0] mask,
  input  wire logic [3:0]  hold_s,
  input  wire logic [11:0] clear,
  output logic      [11:0] held
);

  logic [11:0] detect;
  logic [3:0]  hold_eff;

  assign detect   = sso_pkg::warn_unmasked(raw, mask);
  assign hold_eff = (hold_s > sso_pkg::HOLD_MAX_S) ? sso_pkg::HOLD_MAX_S : hold_s;

  for (genvar i = 0; i < sso_pkg::NWARN; i++) begin : g_warn
    logic [3:0] left;
    logic       timed;

    // Zero hold means no time limit
    assign timed = !sso_pkg::WARN_NO_LIMIT[i] && (hold_eff != 4'h0);

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        held[i] <= 1'b0;
        left    <= 4'h0;
      end else if (detect[i]) begin
        held[i] <= 1'b1;
        left    <= hold_eff;
      end else if (clear[i]) begin
        held[i] <= 1'b0;
      end else if (held[i] && timed && sec_tick) begin
        held[i] <= (left > 4'h1);
        left    <= left - 4'h1;
      end
    end
  end

endmodule

//--- tb/sso_host_model.sv
`timescale 1ns/1ps
module sso_host_model (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic [5:0] chan,
  output logic      [5:0] seen
);
  // Host input stage: a one means the output transistor is on
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seen <= 6'h00;
    end else begin
      seen <= chan;
    end
  end
endmodule

//--- tb/tb_sso_status_out.sv
`timescale 1ns/1ps
module tb_sso_status_out;
  localparam int unsigned TPS = 16;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  wire  logic  hready = hreadyout;
  sso_pkg::sso_cond_t cond, m;
  logic [10:0] outs;
  logic [5:0]  chan, seen;
  logic [11:0] m_held;
  logic [4:0]  m_sel1, m_sel2;
  logic [23:0] m_chmap;
  int miscompares, total_checks;
  int wq[$] = '{1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 22, 14};
  int mq[$] = '{7, 5, 0, 6, 4, 3, 9, 2, 8, 10, 7, 14};
  int holds[$] = '{1, 2, 0};
  sso_status_out #(.TICKS_PER_SEC(TPS)) u_sso_status_out (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cond_in(cond),
    .servo_alarm_out(outs[0]), .servo_ready_out(outs[1]), .brake_release_out(outs[2]),
    .positioning_done_out(outs[3]), .speed_arrival_out(outs[4]),
    .torque_limited_out(outs[5]), .zero_speed_out(outs[6]), .speed_match_out(outs[7]),
    .positioning_done_second_out(outs[8]), .warning_out_first(outs[9]),
    .warning_out_second(outs[10]), .output_channel_one(chan[0]),
    .output_channel_two(chan[1]), .output_channel_three(chan[2]),
    .output_channel_four(chan[3]), .output_channel_five(chan[4]),
    .output_channel_six(chan[5]), .irq(irq));
  sso_host_model u_sso_host_model (.hclk(hclk), .hresetn(hresetn), .chan(chan), .seen(seen));

  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  task automatic test_done();
    $display("Checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", name, exp, got);
      miscompares++;
    end
  endtask

  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rchk(input string name, input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(name, exp, rd);
  endtask

  function automatic logic pick(input logic [4:0] s);
    if (s == 5'h00) return |m_held;
    foreach (wq[k]) if (wq[k] == s) return m_held[k];
    return 1'b0;
  endfunction

  function automatic logic [15:0] exp_func();
    logic [15:0] f;
    f = 16'h0000;
    f[1] = ~m.alarm;
    f[2] = m.ctrl_power & m.main_power & ~m.alarm;
    f[3] = m.brake_release;
    f[4] = m.pos_done;
    f[5] = m.speed_arrived;
    f[6] = m.torque_limited;
    f[7] = m.zero_speed;
    f[8] = m.speed_match;
    f[9] = m.pos_done2;
    f[10] = pick(m_sel1);
    f[11] = pick(m_sel2);
    return f;
  endfunction

  task automatic set_cond(input sso_pkg::sso_cond_t c);
    @(posedge hclk);
    cond <= c;
    m = c;
    repeat (6) @(posedge hclk);
  endtask

  task automatic check_outs();
    logic [15:0] f;
    logic [5:0]  ch;
    f = exp_func();
    for (int k = 0; k < 6; k++) ch[k] = f[m_chmap[4*k +: 4]];
    chk("outputs", {21'h0, f[11:1]}, {21'h0, outs});
    chk("channels", {26'h0, ch}, {26'h0, chan});
    chk("host view", {26'h0, ch}, {26'h0, seen});
  endtask

  initial begin
    repeat (60000) @(posedge hclk);
    miscompares++;
    test_done();
  end

  initial begin
    sso_pkg::sso_cond_t c;
    hresetn = 1'b0;
    hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0;
    cond = '0;
    m_held = 12'h000; m_sel1 = 5'h00; m_sel2 = 5'h00; m_chmap = 24'h674123;
    void'($urandom(55446));
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    // Reset values and unmapped places
    rchk("chmap", 32'h00, 32'h00674123);
    rchk("wsel", 32'h04, 32'h0);
    rchk("wmask", 32'h08, 32'h0);
    rchk("wlatch", 32'h0C, 32'h1);
    rchk("irq mask", 32'h1C, 32'h0);
    rchk("unmapped", 32'h20, 32'h0);
    bus(1'b1, 32'h100, 32'h0);
    rchk("alias", 32'h00, 32'h00674123);
    chk("hresp", 32'h0, {31'h0, hresp});
    $display("Test registers done");
    // Random conditions and channel maps
    for (int n = 0; n < 24; n++) begin
      c = sso_pkg::sso_cond_t'(22'($urandom));
      c.warn = 12'h000;
      if (n >= 8 && n % 4 == 0) begin
        m_chmap = 24'($urandom);
        bus(1'b1, 32'h00, {8'h00, m_chmap});
      end
      set_cond(c);
      check_outs();
    end
    rchk("func", 32'h10, {16'h0, exp_func()});
    bus(1'b1, 32'h10, 32'hFFFF);
    rchk("func ro", 32'h10, {16'h0, exp_func()});
    set_cond('0);
    $display("Test conditions done");
    // Warnings via select, OR, mask, latch
    for (int i = 0; i < 12; i++) begin
      m_sel1 = (i % 2 == 1) ? 5'h00 : 5'(wq[i]);
      m_sel2 = 5'(wq[(i % 2 == 1) ? i : (i + 1) % 12]);
      bus(1'b1, 32'h04, {19'h0, m_sel2, 3'h0, m_sel1});
      c = '0;
      c.warn = 12'(1 << i);
      set_cond(c);
      m_held = c.warn;
      check_outs();
      rchk("wstat", 32'h14, {20'h0, m_held});
      set_cond('0);
      repeat (20) @(posedge hclk);
      if (i == 2 || i == 7) begin
        check_outs();
        bus(1'b1, 32'h14, {20'h0, m_held});
        repeat (3) @(posedge hclk);
      end
      m_held = 12'h000;
      check_outs();
      bus(1'b1, 32'h08, 32'(1 << mq[i]));
      set_cond(c);
      check_outs();
      rchk("masked", 32'h14, 32'h0);
      set_cond('0);
      bus(1'b1, 32'h08, 32'h0);
    end
    $display("Test warnings done");
    // Hold of one, two seconds and no limit
    m_sel1 = 5'h01;
    m_sel2 = 5'h00;
    bus(1'b1, 32'h04, 32'h01);
    foreach (holds[h]) begin
      bus(1'b1, 32'h0C, 32'(holds[h]));
      c = '0;
      c.warn = 12'h001;
      set_cond(c);
      m_held = 12'h001;
      set_cond('0);
      repeat (6) @(posedge hclk);
      if (holds[h] != 1) check_outs();
      repeat ((holds[h] == 0 ? 3 : holds[h]) * TPS) @(posedge hclk);
      if (holds[h] != 0) m_held = 12'h000;
      check_outs();
      bus(1'b1, 32'h14, 32'h001);
      m_held = 12'h000;
      repeat (3) @(posedge hclk);
      check_outs();
    end
    $display("Test hold done");
    // Interrupt status and mask
    bus(1'b1, 32'h18, 32'h7);
    rchk("irq stat", 32'h18, 32'h0);
    bus(1'b1, 32'h1C, 32'h1);
    c = '0;
    c.alarm = 1'b1;
    set_cond(c);
    rchk("irq alarm", 32'h18, 32'h1);
    chk("irq on", 32'h1, {31'h0, irq});
    bus(1'b1, 32'h1C, 32'h0);
    @(posedge hclk);
    chk("irq masked", 32'h0, {31'h0, irq});
    bus(1'b1, 32'h1C, 32'h7);
    bus(1'b1, 32'h18, 32'h1);
    @(posedge hclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    c = '0;
    c.ctrl_power = 1'b1;
    c.main_power = 1'b1;
    set_cond(c);
    check_outs();
    c.main_power = 1'b0;
    set_cond(c);
    check_outs();
    rchk("irq ready", 32'h18, 32'h4);
    chk("irq ready on", 32'h1, {31'h0, irq});
    $display("Test interrupts done");
    test_done();
  end
endmodule
